// ==== rtl/cfd_ratio_ctrl.sv ====
/*
  Core ratio control: chooses the bus-to-core multiplier from the ratio
  strap and the half and quarter speed requests, and reports it.
  Assumes a classic Wishbone master on clk_sys; strap and select pins are
  asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module cfd_ratio_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cfd_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic [5:0] ratioStrap,
  input wire logic halfSpeedPin_b,
  input wire logic quarterSpeedPin_b,
  // Effective ratio
  output logic [7:0] coreMultQuarters,
  output logic [5:0] multiplierCode,
  output logic [1:0] activeMode,
  output logic lowMultiplier
);

  logic [5:0] strapMeta_reg;
  logic [5:0] strapSync_reg;
  logic [1:0] pinMeta_reg;
  logic [1:0] pinSync_reg;
  logic halfSpeedSelect_reg;
  logic quarterSpeedSelect_reg;
  logic refused_reg;
  logic refused_next;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] configWord;
  logic [31:0] statusWord;
  logic busReq;
  logic busWrite;
  logic refuseNow;
  logic reqHalf;
  logic reqQuarter;
  cfd_pkg::cfd_entry_type entry;
  cfd_pkg::cfd_setting_type setting_reg;
  cfd_pkg::cfd_setting_type setting_next;

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strapMeta_reg <= 6'h00;
      strapSync_reg <= 6'h00;
      pinMeta_reg <= 2'h3;
      pinSync_reg <= 2'h3;
    end
    else
    begin
      strapMeta_reg <= ratioStrap;
      strapSync_reg <= strapMeta_reg;
      pinMeta_reg <= {quarterSpeedPin_b, halfSpeedPin_b};
      pinSync_reg <= pinMeta_reg;
    end
  end

  cfd_ratio_rom u_rom (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .strapCode(strapSync_reg),
    .entry(entry)
  );

  assign reqHalf = halfSpeedSelect_reg | ~pinSync_reg[0];
  assign reqQuarter = quarterSpeedSelect_reg | ~pinSync_reg[1];

  // Quarter speed wins when both requests stand
  always_comb
  begin
    setting_next = setting_reg;
    refuseNow = 1'b0;
    if (reqQuarter)
    begin
      if (entry.quarterOk)
      begin
        setting_next.mode = cfd_pkg::MODE_QUARTER;
        setting_next.quarters = entry.baseQuarters >> 2;
        setting_next.code = entry.quarterCode;
      end
      else
        refuseNow = 1'b1;
    end
    else if (reqHalf)
    begin
      if (entry.halfOk)
      begin
        setting_next.mode = cfd_pkg::MODE_HALF;
        setting_next.quarters = entry.baseQuarters >> 1;
        setting_next.code = entry.halfCode;
      end
      else
        refuseNow = 1'b1;
    end
    else
    begin
      setting_next.mode = cfd_pkg::MODE_FULL;
      setting_next.quarters = entry.baseQuarters;
      setting_next.code = strapSync_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      setting_reg <= '{cfd_pkg::MODE_FULL, cfd_pkg::QUARTERS_RESET,
                       cfd_pkg::CODE_RESET};
    else
      setting_reg <= setting_next;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      coreMultQuarters <= cfd_pkg::QUARTERS_RESET;
      multiplierCode <= cfd_pkg::CODE_RESET;
      activeMode <= cfd_pkg::MODE_FULL;
      lowMultiplier <= 1'b0;
    end
    else
    begin
      coreMultQuarters <= setting_next.quarters;
      multiplierCode <= setting_next.code;
      activeMode <= setting_next.mode;
      // Flag for software handling of snoops at slow ratios
      lowMultiplier <= (setting_next.quarters != 8'h00) &&
                       (setting_next.quarters <
                        cfd_pkg::LOW_MULT_QUARTERS);
    end
  end

  // Bus: ack one cycle after the request; writes land on the ack edge
  assign busReq = wb_cyc_i & wb_stb_i;
  assign busWrite = busReq & wb_we_i & ack_reg;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ack_reg <= 1'b0;
    else
      ack_reg <= busReq & ~ack_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      halfSpeedSelect_reg <= 1'b0;
      quarterSpeedSelect_reg <= 1'b0;
    end
    else if (busWrite && wb_sel_i[0] &&
             wb_adr_i == cfd_pkg::CONFIG_OFFSET)
    begin
      halfSpeedSelect_reg <= wb_dat_i[cfd_pkg::HALF_BIT];
      quarterSpeedSelect_reg <= wb_dat_i[cfd_pkg::QUARTER_BIT];
    end
  end

  // Sticky refused flag; write one clears it, a new refusal wins
  always_comb
  begin
    refused_next = refused_reg;
    if (busWrite && wb_sel_i[1] && wb_adr_i == cfd_pkg::STATUS_OFFSET &&
        wb_dat_i[cfd_pkg::STAT_REFUSED_BIT])
      refused_next = 1'b0;
    if (refuseNow)
      refused_next = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      refused_reg <= 1'b0;
    else
      refused_reg <= refused_next;
  end

  always_comb
  begin
    configWord = cfd_pkg::DATA_ZERO;
    configWord[cfd_pkg::HALF_BIT] = halfSpeedSelect_reg;
    configWord[cfd_pkg::QUARTER_BIT] = quarterSpeedSelect_reg;
    configWord[cfd_pkg::CODE_POS0] = setting_reg.code[5];
    configWord[cfd_pkg::CODE_POS1] = setting_reg.code[4];
    configWord[cfd_pkg::CODE_POS2] = setting_reg.code[3];
    configWord[cfd_pkg::CODE_POS3] = setting_reg.code[2];
    configWord[cfd_pkg::CODE_POS4] = setting_reg.code[1];
    configWord[cfd_pkg::CODE_POS5] = setting_reg.code[0];
  end

  always_comb
  begin
    statusWord = cfd_pkg::DATA_ZERO;
    statusWord[cfd_pkg::STAT_QUARTERS_LSB +: 8] = setting_reg.quarters;
    statusWord[cfd_pkg::STAT_LOW_BIT] = lowMultiplier;
    statusWord[cfd_pkg::STAT_REFUSED_BIT] = refused_reg;
    statusWord[cfd_pkg::STAT_MODE_LSB +: 2] = setting_reg.mode;
    statusWord[cfd_pkg::STAT_STRAP_LSB +: 6] = strapSync_reg;
  end

  always_comb
  begin
    case (wb_adr_i)
      cfd_pkg::CONFIG_OFFSET: rdata_next = configWord;
      cfd_pkg::STATUS_OFFSET: rdata_next = statusWord;
      default: rdata_next = cfd_pkg::DATA_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rdata_reg <= cfd_pkg::DATA_ZERO;
    else if (busReq && !ack_reg)
      rdata_reg <= rdata_next;
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule : cfd_ratio_ctrl

`default_nettype wire

// ==== rtl/cfd_pkg.sv ====
/*
  Shared constants and types of the core ratio control: register offsets,
  field positions, reset values, ratio table entry and scaling modes.
  Assumes a 32-bit classic Wishbone register bus.
*/
package cfd_pkg;

  localparam int ADDR_W = 4;
  localparam logic [3:0] CONFIG_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Control bits of hardware_config_reg_one
  localparam int HALF_BIT = 0;
  localparam int QUARTER_BIT = 1;
  // Positions of multiplier_code_field bits, first bit to sixth
  localparam int CODE_POS0 = 15;
  localparam int CODE_POS1 = 16;
  localparam int CODE_POS2 = 17;
  localparam int CODE_POS3 = 18;
  localparam int CODE_POS4 = 19;
  localparam int CODE_POS5 = 14;

  // Status register layout
  localparam int STAT_QUARTERS_LSB = 0;
  localparam int STAT_LOW_BIT = 8;
  localparam int STAT_REFUSED_BIT = 9;
  localparam int STAT_MODE_LSB = 10;
  localparam int STAT_STRAP_LSB = 12;

  // Effective multiplier below 5x, counted in quarters
  localparam logic [7:0] LOW_MULT_QUARTERS = 8'h14;

  localparam logic [7:0] QUARTERS_RESET = 8'h00;
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_FULL = 2'b00,
    MODE_HALF = 2'b01,
    MODE_QUARTER = 2'b10
  } cfd_mode_type;

  typedef struct packed {
    logic known;
    logic [7:0] baseQuarters;
    logic halfOk;
    logic [5:0] halfCode;
    logic quarterOk;
    logic [5:0] quarterCode;
  } cfd_entry_type;

  typedef struct packed {
    cfd_mode_type mode;
    logic [7:0] quarters;
    logic [5:0] code;
  } cfd_setting_type;

endpackage : cfd_pkg

// ==== rtl/cfd_ratio_rom.sv ====
/*
  Ratio table: maps a 6-bit strap code to its base multiplier in quarter
  steps and the reported codes of the halved and quartered ratios.
  Read data are registered; one cycle from code to entry.
*/
`timescale 1ns/1ps
`default_nettype none

module cfd_ratio_rom (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Lookup
  input wire logic [5:0] strapCode,
  output cfd_pkg::cfd_entry_type entry
);

  function automatic cfd_pkg::cfd_entry_type ent(
    input logic [7:0] q,
    input logic hok,
    input logic [5:0] hc,
    input logic qok,
    input logic [5:0] qc
  );
    ent = '{1'b1, q, hok, hc, qok, qc};
  endfunction : ent

  cfd_pkg::cfd_entry_type entry_next;

  // Unsupported divide combinations carry an ok bit of zero
  always_comb
  begin
    entry_next = '0;
    case (strapCode)
      6'h10: entry_next = ent(8'h08, 1'b0, 6'h00, 1'b0, 6'h00);
      6'h20: entry_next = ent(8'h0c, 1'b0, 6'h00, 1'b0, 6'h00);
      6'h28: entry_next = ent(8'h10, 1'b1, 6'h10, 1'b0, 6'h00);
      6'h2c: entry_next = ent(8'h14, 1'b1, 6'h15, 1'b0, 6'h00);
      6'h24: entry_next = ent(8'h16, 1'b1, 6'h35, 1'b0, 6'h00);
      6'h34: entry_next = ent(8'h18, 1'b1, 6'h20, 1'b0, 6'h00);
      6'h14: entry_next = ent(8'h1a, 1'b1, 6'h20, 1'b0, 6'h00);
      6'h08: entry_next = ent(8'h1c, 1'b1, 6'h35, 1'b0, 6'h00);
      6'h04: entry_next = ent(8'h1e, 1'b1, 6'h35, 1'b0, 6'h00);
      6'h30: entry_next = ent(8'h20, 1'b1, 6'h28, 1'b1, 6'h10);
      6'h18: entry_next = ent(8'h22, 1'b1, 6'h28, 1'b0, 6'h00);
      6'h1e: entry_next = ent(8'h24, 1'b1, 6'h1d, 1'b1, 6'h10);
      6'h1c: entry_next = ent(8'h26, 1'b1, 6'h1d, 1'b0, 6'h00);
      6'h2a: entry_next = ent(8'h28, 1'b1, 6'h2c, 1'b1, 6'h15);
      6'h22: entry_next = ent(8'h2a, 1'b1, 6'h2c, 1'b0, 6'h00);
      6'h26: entry_next = ent(8'h2c, 1'b1, 6'h24, 1'b1, 6'h15);
      6'h00: entry_next = ent(8'h2e, 1'b1, 6'h24, 1'b0, 6'h00);
      6'h2e: entry_next = ent(8'h30, 1'b1, 6'h34, 1'b1, 6'h20);
      6'h3e: entry_next = ent(8'h32, 1'b1, 6'h34, 1'b0, 6'h00);
      6'h16: entry_next = ent(8'h34, 1'b1, 6'h14, 1'b1, 6'h20);
      6'h38: entry_next = ent(8'h36, 1'b1, 6'h14, 1'b0, 6'h00);
      6'h32: entry_next = ent(8'h38, 1'b1, 6'h08, 1'b1, 6'h35);
      6'h06: entry_next = ent(8'h3c, 1'b1, 6'h04, 1'b1, 6'h35);
      6'h36: entry_next = ent(8'h40, 1'b1, 6'h30, 1'b1, 6'h28);
      6'h02: entry_next = ent(8'h44, 1'b1, 6'h18, 1'b1, 6'h28);
      6'h0a: entry_next = ent(8'h48, 1'b1, 6'h1e, 1'b1, 6'h1d);
      6'h0e: entry_next = ent(8'h50, 1'b1, 6'h2a, 1'b1, 6'h2c);
      6'h12: entry_next = ent(8'h54, 1'b1, 6'h22, 1'b1, 6'h2c);
      6'h1a: entry_next = ent(8'h60, 1'b1, 6'h2e, 1'b1, 6'h34);
      6'h3a: entry_next = ent(8'h70, 1'b1, 6'h32, 1'b1, 6'h08);
      default: entry_next = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      entry <= '0;
    else
      entry <= entry_next;
  end

endmodule : cfd_ratio_rom

`default_nettype wire

// ==== verification/cfd_ratio_ctrl_checker.sv ====
/*
  Port checker of the core ratio control.
  Assumes it is bound to cfd_ratio_ctrl, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cfd_ratio_ctrl_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cfd_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and ratio
  input wire logic [5:0] ratioStrap,
  input wire logic halfSpeedPin_b,
  input wire logic quarterSpeedPin_b,
  input wire logic [7:0] coreMultQuarters,
  input wire logic [5:0] multiplierCode,
  input wire logic [1:0] activeMode,
  input wire logic lowMultiplier
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_request;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_strapSteady;
    $stable(ratioStrap) [*5];
  endsequence
  sequence s_quarterWrite;
    wb_ack_o && wb_we_i && wb_adr_i == cfd_pkg::CONFIG_OFFSET &&
      wb_sel_i[0] && wb_dat_i[1];
  endsequence
  property p_ackLatency;
    s_request |=> wb_ack_o;
  endproperty
  a_ackLatency: assert property (p_ackLatency) else $error("ack late");
  property p_ackPulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
  property p_codeBits;
    wb_ack_o && !wb_we_i && wb_adr_i == cfd_pkg::CONFIG_OFFSET |->
      {wb_dat_o[15], wb_dat_o[19:16], wb_dat_o[14]} ==
      {$past(multiplierCode[5]), $past(multiplierCode[1]),
       $past(multiplierCode[2]), $past(multiplierCode[3]),
       $past(multiplierCode[4]), $past(multiplierCode[0])};
  endproperty
  a_codeBits: assert property (p_codeBits) else $error("code bits");
  property p_lowFlag;
    lowMultiplier == (coreMultQuarters != 8'h00 && coreMultQuarters < 8'h14);
  endproperty
  a_lowFlag: assert property (p_lowFlag) else $error("low flag");
  property p_fullCode;
    s_strapSteady |->
      activeMode != cfd_pkg::MODE_FULL || multiplierCode == ratioStrap;
  endproperty
  a_fullCode: assert property (p_fullCode) else $error("full code");
  property p_halfRange;
    activeMode == cfd_pkg::MODE_HALF |->
      coreMultQuarters inside {[8'h08:8'h38]};
  endproperty
  a_halfRange: assert property (p_halfRange) else $error("half");
  property p_quarterWrite;
    s_quarterWrite |-> ##2
      (activeMode == cfd_pkg::MODE_QUARTER || $stable(coreMultQuarters));
  endproperty
  a_quarterWrite: assert property (p_quarterWrite) else $error("qw");
  property p_halfPin;
    (!halfSpeedPin_b) [*4] |->
      activeMode != cfd_pkg::MODE_FULL || $stable(coreMultQuarters);
  endproperty
  a_halfPin: assert property (p_halfPin) else $error("half pin");
endmodule : cfd_ratio_ctrl_checker

bind cfd_ratio_ctrl cfd_ratio_ctrl_checker cfd_ratio_ctrl_checker_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ratioStrap(ratioStrap),
  .halfSpeedPin_b(halfSpeedPin_b), .quarterSpeedPin_b(quarterSpeedPin_b),
  .coreMultQuarters(coreMultQuarters), .multiplierCode(multiplierCode),
  .activeMode(activeMode), .lowMultiplier(lowMultiplier));
`default_nettype wire

// ==== verification/cfd_ratio_ctrl_tb_top.sv ====
/*
  Testbench of the core ratio control: Wishbone tasks and a strap table.
  Assumes the checker file is compiled beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module cfd_ratio_ctrl_tb_top;
  logic clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [5:0] ratioStrap, multiplierCode;
  logic halfSpeedPin_b, quarterSpeedPin_b, lowMultiplier;
  logic [7:0] coreMultQuarters;
  logic [1:0] activeMode;
  int errors = 0;
  int compares = 0;
  cfd_ratio_ctrl cfd_ratio_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ratioStrap(ratioStrap),
    .halfSpeedPin_b(halfSpeedPin_b), .quarterSpeedPin_b(quarterSpeedPin_b),
    .coreMultQuarters(coreMultQuarters), .multiplierCode(multiplierCode),
    .activeMode(activeMode), .lowMultiplier(lowMultiplier));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  // One classic cycle; read data land in rd
  task automatic bus(input logic we, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
      errors++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : bus
  function automatic logic [31:0] cfgWord(logic [5:0] c, logic [1:0] ctl);
    cfgWord = {12'h000, c[1], c[2], c[3], c[4], c[5], c[0], 12'h000,
      ctl};
  endfunction : cfgWord
  task automatic checkOut(logic [7:0] q, logic [5:0] c, logic [1:0] m);
    check({coreMultQuarters, multiplierCode, activeMode, lowMultiplier},
      {q, c, m, q != 8'h00 && q < 8'h14});
  endtask : checkOut
  task automatic runEntry(logic [5:0] s, logic [7:0] fq, hq, logic [5:0] hc,
    logic hOk, logic [7:0] qq, logic [5:0] qc, logic qOk);
    logic [7:0] q;
    logic [5:0] c;
    logic [1:0] m;
    bus(1'b1, 4'h0, 32'h0000_0000);
    bus(1'b1, 4'h4, 32'h0000_0200);
    ratioStrap <= s;
    settle(6);
    checkOut(fq, s, 2'b00);
    bus(1'b1, 4'h0, 32'h0000_0001);
    settle(1);
    q = hOk ? hq : fq;
    c = hOk ? hc : s;
    m = hOk ? 2'b01 : 2'b00;
    checkOut(q, c, m);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, cfgWord(c, 2'b01));
    bus(1'b1, 4'h0, 32'h0000_0002);
    settle(1);
    q = qOk ? qq : q;
    c = qOk ? qc : c;
    m = qOk ? 2'b10 : m;
    checkOut(q, c, m);
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(rd[17:0],
      {s, m, !(hOk && qOk), q != 8'h00 && q < 8'h14, q});
    $display("strap %h test done", s);
  endtask : runEntry
  initial
  begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h0f, 32'h0000_0000};
    {ratioStrap, halfSpeedPin_b, quarterSpeedPin_b} = {6'h1a, 2'b11};
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    settle(5);
    checkOut(8'h60, 6'h1a, 2'b00);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, cfgWord(6'h1a, 2'b00));
    bus(1'b1, 4'h8, 32'h0000_0003);
    bus(1'b0, 4'h8, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    settle(1);
    checkOut(8'h60, 6'h1a, 2'b00);
    $display("reset test done");
    runEntry(6'h10, 8'h08, 8'h00, 6'h00, 1'b0, 8'h00, 6'h00, 1'b0);
    runEntry(6'h24, 8'h16, 8'h0b, 6'h35, 1'b1, 8'h00, 6'h00, 1'b0);
    runEntry(6'h1e, 8'h24, 8'h12, 6'h1d, 1'b1, 8'h09, 6'h10, 1'b1);
    runEntry(6'h3a, 8'h70, 8'h38, 6'h32, 1'b1, 8'h1c, 6'h08, 1'b1);
    runEntry(6'h1a, 8'h60, 8'h30, 6'h2e, 1'b1, 8'h18, 6'h34, 1'b1);
    bus(1'b1, 4'h0, 32'h0000_0000);
    halfSpeedPin_b <= 1'b0;
    settle(4);
    checkOut(8'h30, 6'h2e, 2'b01);
    @(posedge clk_sys);
    quarterSpeedPin_b <= 1'b0;
    settle(4);
    checkOut(8'h18, 6'h34, 2'b10);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, cfgWord(6'h34, 2'b00));
    {halfSpeedPin_b, quarterSpeedPin_b} <= 2'b11;
    settle(4);
    checkOut(8'h60, 6'h1a, 2'b00);
    $display("pin test done");
    stop_test();
  end
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    errors++;
    stop_test();
  end
endmodule : cfd_ratio_ctrl_tb_top
`default_nettype wire
